/* rtl/cmpref_pkg.sv */
// Purpose: Shared constants and types for the comparator and reference
// Assumes: 8-bit register port, 200 MHz clock
// Notes:   Offsets are byte addresses on the register port
package cmpref_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // Register offsets
  localparam logic [7:0] OFS_PORT_A_DATA      = 8'h05;
  localparam logic [7:0] OFS_INTERRUPT_CTRL   = 8'h0B;
  localparam logic [7:0] OFS_PERIPH_FLAGS     = 8'h0C;
  localparam logic [7:0] OFS_COMPARATOR_CTRL  = 8'h19;
  localparam logic [7:0] OFS_PORT_A_DIRECTION = 8'h85;
  localparam logic [7:0] OFS_PERIPH_ENABLES   = 8'h8C;
  localparam logic [7:0] OFS_REFERENCE_CTRL   = 8'h99;

  // Reset values
  localparam logic [7:0] RST_INTERRUPT_CTRL   = 8'h00;
  localparam logic [7:0] RST_PERIPH_FLAGS     = 8'h00;
  localparam logic [4:0] RST_COMPARATOR_CTRL  = 5'h00;
  localparam logic [5:0] RST_PORT_A_DIRECTION = 6'h3F;
  localparam logic [7:0] RST_PERIPH_ENABLES   = 8'h00;
  localparam logic [7:0] RST_REFERENCE_CTRL   = 8'h00;

  // Implemented bits
  localparam logic [7:0] MASK_PERIPH   = 8'hC9;
  localparam logic [7:0] MASK_REF_CTRL = 8'hAF;

  // Field positions
  localparam int GLOBAL_IRQ_BIT   = 7;
  localparam int PERIPH_IRQ_BIT   = 6;
  localparam int CHANGE_FLAG_BIT  = 3;
  localparam int RESULT_BIT       = 6;
  localparam int INVERT_BIT       = 4;
  localparam int SWITCH_BIT       = 3;
  localparam int REF_POWER_BIT    = 7;
  localparam int REF_RANGE_BIT    = 5;
  localparam int OUT_PIN_BIT      = 2;

  // Comparator modes
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [2:0] MODE_OFF   = 3'h7;
  localparam logic [2:0] MODE_OUT_A = 3'h1;
  localparam logic [2:0] MODE_OUT_B = 3'h3;
  localparam logic [2:0] MODE_OUT_C = 3'h6;

  // Analog masks over the six port pins
  localparam logic [5:0] ANALOG_RESET = 6'h07;
  localparam logic [5:0] ANALOG_ON    = 6'h03;
  localparam logic [5:0] ANALOG_OFF   = 6'h00;

  // Reference level in 96ths of supply
  localparam logic [6:0] REF_HIGH_BASE = 7'h18;

  // Settling time after a mode change
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SETTLE_NS     = 10000;
  localparam int SETTLE_CYCLES =
    (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage

/* rtl/input_conditioner.sv */
// Purpose: Pin synchronisers and settle timer after a mode change
// Assumes: Inputs are asynchronous to clk
// Notes:   Settled drops for SETTLE cycles after each restart pulse
`timescale 1ns/1ps
module input_conditioner #(
  parameter int WIDTH  = 7,
  parameter int SETTLE = 2000
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic             restart,
  output logic      [WIDTH-1:0] sync_out,
  output logic                  settled
);

  localparam int CW = $clog2(SETTLE + 1);

  logic [WIDTH-1:0] meta_q;
  logic [CW-1:0]    count_q;

  initial
  begin
    if (WIDTH < 1 || SETTLE < 1)
      $error("input_conditioner: bad parameters");
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      count_q <= '0;
    else if (restart)
      count_q <= CW'(SETTLE);
    else if (count_q != '0)
      count_q <= count_q - CW'(1);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      settled <= 1'b1;
    else
      settled <= !restart && (count_q <= CW'(1));
  end

endmodule

/* rtl/comparator_vref_control.sv */
// Purpose: Register file and control for one comparator and its reference
// Assumes: Comparator result and port pins arrive asynchronously
// Notes:   Reference level is reported in 96ths of the supply
`timescale 1ns/1ps
module comparator_vref_control (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire cmpref_pkg::reg_req_t  req,
  output logic [7:0]                 rdata,
  input  wire logic                  compare_raw,
  input  wire logic [5:0]            port_a_pins,
  input  wire logic                  sleep_active,
  output logic                       compare_output_pin_o,
  output logic                       compare_output_pin_oe_n,
  output logic                       comparator_enable,
  output logic [2:0]                 comparator_mode_code,
  output logic                       input_switch,
  output logic                       reference_power_on,
  output logic                       reference_range_select,
  output logic [3:0]                 reference_step_value,
  output logic [6:0]                 internal_reference_level,
  output logic                       result_valid,
  output logic                       irq,
  output logic                       wake
);
  import cmpref_pkg::*;

  logic [7:0] interrupt_control_q;
  logic [7:0] peripheral_flags_q;
  logic [4:0] comparator_control_q;
  logic [5:0] port_a_direction_q;
  logic [7:0] peripheral_enables_q;
  logic [7:0] reference_control_q;
  logic       latched_result_q;
  logic       compare_change_flag_d;
  logic [7:0] rdata_d;

  logic [6:0] sync_vec;
  logic       settled;
  logic       raw_sync;
  logic [5:0] pins_sync;

  // Register decode
  wire hit_intc = req.addr == OFS_INTERRUPT_CTRL;
  wire hit_flag = req.addr == OFS_PERIPH_FLAGS;
  wire hit_cmp  = req.addr == OFS_COMPARATOR_CTRL;
  wire hit_dir  = req.addr == OFS_PORT_A_DIRECTION;
  wire hit_pie  = req.addr == OFS_PERIPH_ENABLES;
  wire hit_ref  = req.addr == OFS_REFERENCE_CTRL;
  wire hit_port = req.addr == OFS_PORT_A_DATA;

  wire wr_intc = req.wr && hit_intc;
  wire wr_flag = req.wr && hit_flag;
  wire wr_cmp  = req.wr && hit_cmp;
  wire wr_dir  = req.wr && hit_dir;
  wire wr_pie  = req.wr && hit_pie;
  wire wr_ref  = req.wr && hit_ref;
  wire cmp_access = (req.wr || req.rd) && hit_cmp;

  // Mode decode
  wire [2:0] mode     = comparator_control_q[2:0];
  wire       invert   = comparator_control_q[INVERT_BIT];
  wire       mode_on  = mode != MODE_RESET && mode != MODE_OFF;
  wire       out_mode = mode == MODE_OUT_A || mode == MODE_OUT_B ||
                        mode == MODE_OUT_C;
  wire [5:0] analog_mask = (mode == MODE_RESET) ? ANALOG_RESET :
                           (mode == MODE_OFF)   ? ANALOG_OFF   :
                                                  ANALOG_ON;
  wire mode_change = wr_cmp && req.wdata[2:0] != mode;

  // Reported result: synchronised raw compare, optionally inverted
  wire result_live = mode_on && (raw_sync ^ invert);
  wire mismatch    = result_live != latched_result_q;

  // Interrupt qualifiers
  wire cmp_flag  = peripheral_flags_q[CHANGE_FLAG_BIT];
  wire cmp_en    = peripheral_enables_q[CHANGE_FLAG_BIT];
  wire periph_en = interrupt_control_q[PERIPH_IRQ_BIT];
  wire global_en = interrupt_control_q[GLOBAL_IRQ_BIT];

  // Reference ladder in 96ths of supply
  wire [3:0] step  = reference_control_q[3:0];
  wire [6:0] low_l  = {1'b0, step, 2'b00};
  wire [6:0] high_l = REF_HIGH_BASE + {2'b00, step, 1'b0} +
                      {3'b000, step};
  wire [6:0] level_d = !reference_control_q[REF_POWER_BIT] ? 7'h00 :
                       reference_control_q[REF_RANGE_BIT] ? low_l :
                                                            high_l;

  assign raw_sync  = sync_vec[6];
  assign pins_sync = sync_vec[5:0];

  input_conditioner #(
    .WIDTH  (7),
    .SETTLE (SETTLE_CYCLES)
  ) u_cond (
    .clk      (clk),
    .nrst     (nrst),
    .async_in ({compare_raw, port_a_pins}),
    .restart  (mode_change),
    .sync_out (sync_vec),
    .settled  (settled)
  );

  // Flag: hardware set wins over a software clear
  assign compare_change_flag_d =
    (mismatch && !cmp_access) ||
    (wr_flag ? req.wdata[CHANGE_FLAG_BIT] : cmp_flag);

  // Read mux
  always_comb
  begin
    rdata_d = 8'h00;
    if (req.rd)
    begin
      if (hit_intc)
        rdata_d = interrupt_control_q;
      else if (hit_flag)
        rdata_d = peripheral_flags_q;
      else if (hit_cmp)
        rdata_d = {1'b0, result_live, 1'b0, comparator_control_q};
      else if (hit_dir)
        rdata_d = {2'b00, port_a_direction_q};
      else if (hit_pie)
        rdata_d = peripheral_enables_q;
      else if (hit_ref)
        rdata_d = reference_control_q;
      else if (hit_port)
        rdata_d = {2'b00, pins_sync & ~analog_mask};
    end
  end

  // Control registers; sleep and wake never touch them
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      interrupt_control_q  <= RST_INTERRUPT_CTRL;
      comparator_control_q <= RST_COMPARATOR_CTRL;
      port_a_direction_q   <= RST_PORT_A_DIRECTION;
      peripheral_enables_q <= RST_PERIPH_ENABLES;
      reference_control_q  <= RST_REFERENCE_CTRL;
    end
    else
    begin
      if (wr_intc)
        interrupt_control_q <= req.wdata;
      if (wr_cmp)
        comparator_control_q <= req.wdata[4:0];
      if (wr_dir)
        port_a_direction_q <= req.wdata[5:0];
      if (wr_pie)
        peripheral_enables_q <= req.wdata & MASK_PERIPH;
      if (wr_ref)
        reference_control_q <= req.wdata & MASK_REF_CTRL;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      peripheral_flags_q <= RST_PERIPH_FLAGS;
      latched_result_q   <= 1'b0;
    end
    else
    begin
      if (wr_flag)
        peripheral_flags_q <= req.wdata & MASK_PERIPH;
      peripheral_flags_q[CHANGE_FLAG_BIT] <= compare_change_flag_d;
      if (cmp_access)
        latched_result_q <= result_live;
    end
  end

  // Registered outputs
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata                    <= 8'h00;
      compare_output_pin_oe_n  <= 1'b1;
      comparator_enable        <= 1'b0;
      comparator_mode_code     <= MODE_RESET;
      input_switch             <= 1'b0;
      reference_power_on       <= 1'b0;
      reference_range_select   <= 1'b0;
      reference_step_value     <= 4'h0;
      internal_reference_level <= 7'h00;
      result_valid             <= 1'b0;
      irq                      <= 1'b0;
      wake                     <= 1'b0;
    end
    else
    begin
      rdata                    <= rdata_d;
      compare_output_pin_oe_n  <=
        !(out_mode && !port_a_direction_q[OUT_PIN_BIT]);
      comparator_enable        <= mode_on;
      comparator_mode_code     <= mode;
      input_switch             <= comparator_control_q[SWITCH_BIT];
      reference_power_on       <=
        reference_control_q[REF_POWER_BIT];
      reference_range_select   <= reference_control_q[REF_RANGE_BIT];
      reference_step_value     <= step;
      internal_reference_level <= level_d;
      result_valid             <= mode_on && settled;
      irq    <= cmp_flag && cmp_en && periph_en && global_en;
      wake   <= sleep_active && mode_on && cmp_flag && cmp_en;
    end
  end

  // Pin path bypasses the clock on purpose
  assign compare_output_pin_o = out_mode && (compare_raw ^ invert);

  a_result_read: assert property (
    @(posedge clk) disable iff (!nrst)
    req.rd && hit_cmp |=> rdata[RESULT_BIT] == $past(result_live) &&
      rdata[4:0] == $past(comparator_control_q))
    else $error("comparator read data wrong");

  a_port_analog_zero: assert property (
    @(posedge clk) disable iff (!nrst)
    req.rd && hit_port |=> (rdata[5:0] & $past(analog_mask)) == 6'h00)
    else $error("analog pin read nonzero");

  a_ref_low_range: assert property (
    @(posedge clk) disable iff (!nrst)
    reference_control_q[REF_POWER_BIT] && reference_control_q[REF_RANGE_BIT]
    |=> internal_reference_level == 7'($past(step) * 4))
    else $error("low range level wrong");

  a_ref_high_range: assert property (
    @(posedge clk) disable iff (!nrst)
    reference_control_q[REF_POWER_BIT] && !reference_control_q[REF_RANGE_BIT]
    |=> internal_reference_level == 7'(24 + $past(step) * 3))
    else $error("high range level wrong");

  a_flag_on_change: assert property (
    @(posedge clk) disable iff (!nrst)
    mismatch && !cmp_access |=> cmp_flag)
    else $error("change did not set flag");

  a_flag_sw_write: assert property (
    @(posedge clk) disable iff (!nrst)
    wr_flag && !mismatch |=> cmp_flag == $past(req.wdata[CHANGE_FLAG_BIT]))
    else $error("flag write not honoured");

  a_latch_refresh: assert property (
    @(posedge clk) disable iff (!nrst)
    cmp_access |=> !mismatch || $changed(result_live))
    else $error("access did not end mismatch");

  a_irq_gating: assert property (
    @(posedge clk) disable iff (!nrst)
    irq |-> $past(cmp_flag && cmp_en && periph_en && global_en))
    else $error("interrupt without all enables");

  a_oe_follows_dir: assert property (
    @(posedge clk) disable iff (!nrst)
    out_mode && $stable(out_mode) && $stable(port_a_direction_q)
    |-> compare_output_pin_oe_n == port_a_direction_q[OUT_PIN_BIT])
    else $error("pin enable not from direction bit");

  a_mode_off: assert property (
    @(posedge clk) disable iff (!nrst)
    mode == MODE_OFF |=> !comparator_enable ##1 !result_valid)
    else $error("off mode left comparator on");

  a_settle_hold: assert property (
    @(posedge clk) disable iff (!nrst)
    mode_change |=> ##1 !result_valid [*8])
    else $error("result valid during settling");

  a_wake_sleep: assert property (
    @(posedge clk) disable iff (!nrst)
    sleep_active && mode_on && cmp_flag && cmp_en |=> wake)
    else $error("no wake from comparator");

endmodule

/* verification/analog_side_model.sv */
// Purpose: Analog side seen by the comparator block
// Assumes: Bench sets levels, model moves them after a clock edge
// Notes:   Pin levels are plain digital levels here
`timescale 1ns/1ps
module analog_side_model (
  input  wire logic       clk,
  input  wire logic       level,
  input  wire logic [5:0] pins,
  output logic            compare_raw,
  output logic [5:0]      port_a_pins
);
  // Raw comparison and pin levels change off the edge
  always_ff @(posedge clk)
  begin
    compare_raw <= level;
    port_a_pins <= pins;
  end
endmodule

/* verification/comparator_vref_control_tb.sv */
// Purpose: Self-checking bench for the comparator and reference block
// Assumes: 200 MHz clock, register port with read data one cycle later
// Notes:   Settle wait uses the full settle time of the design
`timescale 1ns/1ps
module comparator_vref_control_tb;
  import cmpref_pkg::*;
  logic           clk = 1'b0;
  logic           nrst = 1'b0;
  reg_req_t       req = '0;
  logic [7:0]     rdata;
  logic           level = 1'b0;
  logic [5:0]     pins = 6'h3F;
  logic           sleep_active = 1'b0;
  logic           compare_raw;
  logic [5:0]     port_a_pins;
  logic           pin_o;
  logic           pin_oe_n;
  logic           cmp_en;
  logic [6:0]     ref_level;
  logic           result_valid;
  logic           irq;
  logic           wake;
  logic           ref_on;
  logic           ref_low;
  logic [3:0]     ref_step;
  logic [2:0]     mode_code;
  logic           in_sw;
  logic [2:0]     mc;
  logic           on_m;
  logic           out_m;
  logic [7:0]     exp_m;
  int             fails = 0;
  int             tests_run = 0;
  logic [7:0]     ofs [8] = '{OFS_INTERRUPT_CTRL, OFS_PERIPH_FLAGS,
    OFS_COMPARATOR_CTRL, OFS_PORT_A_DIRECTION, OFS_PERIPH_ENABLES,
    OFS_REFERENCE_CTRL, 8'h40, OFS_PORT_A_DATA};
  logic [7:0]     rst [8] = '{8'h00, 8'h00, 8'h00, 8'h3F, 8'h00, 8'h00,
    8'h00, 8'h38};

  always #2.5 clk = ~clk;

  analog_side_model i_analog_side_model (
    .clk         (clk),
    .level       (level),
    .pins        (pins),
    .compare_raw (compare_raw),
    .port_a_pins (port_a_pins)
  );

  comparator_vref_control i_comparator_vref_control (
    .clk                      (clk),
    .nrst                     (nrst),
    .req                      (req),
    .rdata                    (rdata),
    .compare_raw              (compare_raw),
    .port_a_pins              (port_a_pins),
    .sleep_active             (sleep_active),
    .compare_output_pin_o     (pin_o),
    .compare_output_pin_oe_n  (pin_oe_n),
    .comparator_enable        (cmp_en),
    .comparator_mode_code     (mode_code),
    .input_switch             (in_sw),
    .reference_power_on       (ref_on),
    .reference_range_select   (ref_low),
    .reference_step_value     (ref_step),
    .internal_reference_level (ref_level),
    .result_valid             (result_valid),
    .irq                      (irq),
    .wake                     (wake)
  );

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    #1 chk(rdata, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_valid();
    for (int i = 0; i < 2200; i++)
    begin
      @(posedge clk);
      #1;
      if (result_valid === 1'b1)
        return;
    end
    fails++;
    $display("unexpected at %0t: result never settled", $time);
    finish_test();
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    idle(3);
    chk({7'h00, cmp_en}, 8'h00);
    chk({7'h00, pin_oe_n}, 8'h01);
    for (int i = 0; i < 8; i++)
      rd(ofs[i], rst[i]);
    wr(OFS_REFERENCE_CTRL, 8'hFF);
    rd(OFS_REFERENCE_CTRL, 8'hAF);
    for (int s = 0; s < 16; s++)
    begin
      wr(OFS_REFERENCE_CTRL, 8'hA0 | 8'(s));
      idle(2);
      chk({1'b0, ref_level}, 8'(4 * s));
      chk({ref_on, 1'b0, ref_low, 1'b0, ref_step}, 8'hA0 | 8'(s));
      wr(OFS_REFERENCE_CTRL, 8'h80 | 8'(s));
      idle(2);
      chk({1'b0, ref_level}, 8'(24 + 3 * s));
      chk({ref_on, 1'b0, ref_low, 1'b0, ref_step}, 8'h80 | 8'(s));
    end
    wr(OFS_REFERENCE_CTRL, 8'h2F);
    idle(2);
    chk({1'b0, ref_level}, 8'h00);
    // Mode change made with the interrupt enables still off
    wr(OFS_COMPARATOR_CTRL, 8'h42);
    rd(OFS_COMPARATOR_CTRL, 8'h02);
    chk({7'h00, result_valid}, 8'h00);
    wait_valid();
    rd(OFS_COMPARATOR_CTRL, 8'h02);
    wr(OFS_PERIPH_FLAGS, 8'h00);
    wr(OFS_PERIPH_ENABLES, 8'h08);
    wr(OFS_INTERRUPT_CTRL, 8'hC0);
    level <= 1'b1;
    idle(8);
    chk({7'h00, irq}, 8'h01);
    rd(OFS_PERIPH_FLAGS, 8'h08);
    wr(OFS_PERIPH_FLAGS, 8'h00);
    rd(OFS_PERIPH_FLAGS, 8'h08);
    rd(OFS_COMPARATOR_CTRL, 8'h42);
    wr(OFS_PERIPH_FLAGS, 8'h00);
    rd(OFS_PERIPH_FLAGS, 8'h00);
    wr(OFS_COMPARATOR_CTRL, 8'h12);
    rd(OFS_COMPARATOR_CTRL, 8'h12);
    wr(OFS_INTERRUPT_CTRL, 8'h00);
    rd(OFS_COMPARATOR_CTRL, 8'h12);
    wr(OFS_PERIPH_FLAGS, 8'h00);
    level <= 1'b0;
    idle(8);
    rd(OFS_PERIPH_FLAGS, 8'h08);
    chk({7'h00, irq}, 8'h00);
    wr(OFS_REFERENCE_CTRL, 8'hA3);
    sleep_active <= 1'b1;
    idle(3);
    chk({7'h00, wake}, 8'h01);
    chk({1'b0, ref_level}, 8'h0C);
    chk({7'h00, cmp_en}, 8'h01);
    sleep_active <= 1'b0;
    idle(2);
    rd(OFS_COMPARATOR_CTRL, 8'h52);
    rd(OFS_REFERENCE_CTRL, 8'hA3);
    wr(OFS_PERIPH_FLAGS, 8'h00);
    rd(OFS_PERIPH_FLAGS, 8'h00);
    wr(OFS_PERIPH_FLAGS, 8'h08);
    rd(OFS_PERIPH_FLAGS, 8'h08);
    wr(OFS_COMPARATOR_CTRL, 8'h01);
    idle(2);
    chk({7'h00, pin_oe_n}, 8'h01);
    wr(OFS_PORT_A_DIRECTION, 8'h3B);
    idle(2);
    chk({7'h00, pin_oe_n}, 8'h00);
    level <= 1'b1;
    idle(2);
    chk({7'h00, pin_o}, 8'h01);
    rd(OFS_PORT_A_DATA, 8'h3C);
    // Every mode code with the input switch set and the pin enabled
    for (int m = 0; m < 8; m++)
    begin
      mc = 3'(m);
      on_m = mc != MODE_RESET && mc != MODE_OFF;
      out_m = mc == MODE_OUT_A || mc == MODE_OUT_B || mc == MODE_OUT_C;
      exp_m = {4'h0, on_m, !out_m, out_m, 1'b1};
      wr(OFS_COMPARATOR_CTRL, 8'h08 | 8'(m));
      idle(2);
      chk({5'h00, mode_code}, {5'h00, mc});
      chk({4'h0, cmp_en, pin_oe_n, pin_o, in_sw}, exp_m);
    end
    wr(OFS_COMPARATOR_CTRL, 8'h07);
    idle(2);
    chk({7'h00, cmp_en}, 8'h00);
    finish_test();
  end
endmodule
